// ===== bench/jesd_rx_model.sv
`timescale 1ns/10ps
// far-side receiver: asks for sync, lets go after four good commas
module jesd_rx_model (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [9:0] lane_symbol,
   input wire logic want_sync,
   output logic sync_request_n
);
   logic [2:0] k_run;
   logic is_k;
   assign is_k = lane_symbol == jesd_tx_pkg::SYM_K_NEG || lane_symbol == jesd_tx_pkg::SYM_K_POS;
   // sync request and comma counting
   always_ff @(posedge aclk) begin
      if (!aresetn || !want_sync) begin
         sync_request_n <= 1'b0;
         k_run <= 3'h0;
      end else begin
         if (is_k && k_run != 3'h4) k_run <= k_run + 3'h1;
         else if (!is_k && !sync_request_n) k_run <= 3'h0;
         if (k_run == 3'h4) sync_request_n <= 1'b1;
      end
   end
endmodule

// ===== bench/jesd_tx_link_framer_tb_top.sv
`timescale 1ns/10ps
module jesd_tx_link_framer_tb_top;
   localparam logic [9:0] SYM_A_NEG = 10'h0F3;
   localparam logic [9:0] SYM_A_POS = 10'h30C;
   typedef struct {logic [7:0] addr; logic [31:0] rst; logic [31:0] wv; logic [31:0] back; logic [1:0] resp;} row_type;
   row_type rows [4] = '{'{8'h00, 32'h13, 32'h13, 32'h13, 2'h0}, '{8'h04, 32'h1CD91, 32'h1CD91, 32'h1CD91, 2'h0},
      '{8'h0C, 32'h15A, 32'hFFFFFFFF, 32'hFFF, 2'h0}, '{8'h10, 32'h0, 32'h1, 32'h0, 2'h2}};
   logic aclk = 1'b0;
   logic aresetn, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
   logic sync_request_n, sysref, sysref_run, want_sync, sample_ready;
   logic [7:0] awaddr, araddr;
   logic [31:0] wdata, rdata, rd;
   logic [1:0] bresp, rresp, rsp;
   logic [63:0] lane_samples;
   logic [39:0] lane_symbols;
   logic [3:0] lane_enable;
   logic [9:0] cap [256];
   int fail_count = 0;
   int cmp_count = 0;
   int cyc = 0;
   int n;
   logic [2:0] sr_cnt = 3'h0;
   jesd_tx_link_framer i_jesd_tx_link_framer (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
      .awready(awready), .wdata(wdata), .wstrb(4'hF), .wvalid(wvalid), .wready(wready), .bresp(bresp),
      .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
      .rresp(rresp), .rvalid(rvalid), .rready(rready), .sync_request_n(sync_request_n), .sysref(sysref),
      .overrange(1'b0), .fast_detect(1'b0), .lane_samples(lane_samples), .sample_ready(sample_ready),
      .lane_symbols(lane_symbols), .lane_enable(lane_enable));
   jesd_rx_model i_jesd_rx_model (.aclk(aclk), .aresetn(aresetn), .lane_symbol(lane_symbols[9:0]),
      .want_sync(want_sync), .sync_request_n(sync_request_n));
   // clock of 100 ns period and link timing pulse of 800 ns period, driven on the edge
   always #50 aclk = ~aclk;
   always @(posedge aclk) begin
      sr_cnt <= 3'(sr_cnt + 3'h1);
      sysref <= sysref_run && !sr_cnt[2];
   end
   // hang guard
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         fail_count++;
         $display("timeout at %0t", $time);
         give_verdict();
      end
   end
   function automatic logic is_sym(input logic [9:0] s, input logic [9:0] a, input logic [9:0] b);
      return s === a || s === b;
   endfunction
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         fail_count++;
         $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
      end
   endtask
   task automatic give_verdict();
      $display("compares %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   // one write: address and data offered together
   task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      logic done;
      done = 1'b0;
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      while (!done) begin
         @(posedge aclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
         if (bvalid) begin
            r = bresp;
            done = 1'b1;
         end
      end
   endtask
   task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      logic done;
      done = 1'b0;
      araddr <= a;
      arvalid <= 1'b1;
      while (!done) begin
         @(posedge aclk);
         if (arready) arvalid <= 1'b0;
         if (rvalid) begin
            d = rdata;
            r = rresp;
            done = 1'b1;
         end
      end
   endtask
   // main sequence
   initial begin
      {aresetn, awvalid, wvalid, arvalid, want_sync} = 5'h0;
      {awaddr, araddr, wdata} = 48'h0;
      {bready, rready, sysref_run} = 3'h7;
      lane_samples = 64'h0000_0000_1555_2AAA;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      check({26'h0, lane_enable, bvalid, rvalid}, 32'h0);
      @(posedge aclk);
      for (int i = 0; i < 4; i++) begin
         axi_read(rows[i].addr, rd, rsp);
         check(rd, rows[i].rst);
         axi_write(rows[i].addr, rows[i].wv, rsp);
         check({30'h0, rsp}, {30'h0, rows[i].resp});
         axi_read(rows[i].addr, rd, rsp);
         check({rd[29:0], rsp}, {rows[i].back[29:0], rows[i].resp});
      end
      $display("registers done");
      check({28'h0, lane_enable}, 32'h3);
      repeat (8) begin
         @(posedge aclk);
         check({is_sym(lane_symbols[9:0], 10'h0FA, 10'h305), is_sym(lane_symbols[19:10], 10'h0FA, 10'h305)}, 32'h3);
      end
      sysref_run <= 1'b0;
      want_sync <= 1'b1;
      n = 0;
      while (!is_sym(lane_symbols[9:0], 10'h0F4, 10'h30B) && n < 200) begin
         @(posedge aclk);
         n++;
      end
      check({31'h0, n <= 80}, 32'h1);
      for (int i = 0; i < 256; i++) begin
         cap[i] = lane_symbols[9:0];
         @(posedge aclk);
      end
      for (int m = 0; m < 4; m++) begin
         check({is_sym(cap[64 * m], 10'h0F4, 10'h30B), is_sym(cap[64 * m + 63], SYM_A_NEG, SYM_A_POS)}, 32'h3);
      end
      check({31'h0, is_sym(cap[1], 10'h1D4, 10'h22B)}, 32'h1);
      check({31'h0, is_sym(cap[65], 10'h0F2, 10'h30D)}, 32'h1);
      $display("alignment done");
      n = 0;
      repeat (64) begin
         @(posedge aclk);
         n += sample_ready;
      end
      check(n, 32);
      // status: data state, synced, S of two, no high density
      axi_read(jesd_tx_pkg::STATUS_OFFSET, rd, rsp);
      check(rd, 32'h0000_020C);
      // scrambling off: octets go out plain, repeated frame ends become F or A
      axi_write(jesd_tx_pkg::CTRL_OFFSET, 32'h0000_0011, rsp);
      check({30'h0, rsp}, 32'h0);
      repeat (8) @(posedge aclk);
      while (!sample_ready) @(posedge aclk);
      @(posedge aclk);
      check({12'h000, lane_symbols[19:0]}, {12'h000, 10'h2A5, 10'h15A});
      @(posedge aclk);
      check({31'h0, is_sym(lane_symbols[9:0], 10'h0F8, 10'h307) | is_sym(lane_symbols[9:0], SYM_A_NEG, SYM_A_POS)},
         32'h1);
      $display("data done");
      want_sync <= 1'b0;
      repeat (8) @(posedge aclk);
      check({31'h0, is_sym(lane_symbols[9:0], 10'h0FA, 10'h305)}, 32'h1);
      $display("resync done");
      // reset in mid-run: registers back to defaults, link back to commas
      aresetn <= 1'b0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      check({26'h0, lane_enable, bvalid, rvalid}, 32'h0);
      @(posedge aclk);
      axi_read(jesd_tx_pkg::CTRL_OFFSET, rd, rsp);
      check(rd, jesd_tx_pkg::CTRL_RESET);
      repeat (4) @(posedge aclk);
      check({31'h0, is_sym(lane_symbols[9:0], 10'h0FA, 10'h305)}, 32'h1);
      $display("reset done");
      give_verdict();
   end
endmodule

// ===== verilog/jesd_tx_link_framer.sv
`timescale 1ns/10ps
module jesd_tx_link_framer (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [7:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   input wire logic sync_request_n,
   input wire logic sysref,
   input wire logic overrange,
   input wire logic fast_detect,
   input wire logic [63:0] lane_samples,
   output logic sample_ready,
   output logic [39:0] lane_symbols,
   output logic [3:0] lane_enable
);

   typedef struct packed {
      jesd_tx_pkg::link_state_type state;
      logic [3:0] pos;
      logic [4:0] frame;
      logic [1:0] mf;
      logic [3:0] pin_a;
      logic [3:0] pin_b;
      logic sysref_d;
      logic [31:0] ctrl;
      logic [31:0] fmt;
      logic [31:0] ident;
      logic aw_held;
      logic [7:0] aw_addr;
      logic w_held;
      logic [31:0] w_data;
      logic [3:0] w_strb;
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic [15:0] prn;
      logic [3:0][9:0] sym;
      logic [3:0] rd;
      logic [3:0][14:0] scr;
      logic [3:0][7:0] last_oct;
      logic [3:0][7:0] low_byte;
      logic [3:0] lane_en;
      logic sample_ready;
   } state_type;

   state_type r;
   state_type n;

   // derived link parameters
   logic [2:0] f_code;
   logic [1:0] l_code;
   logic [1:0] m_code;
   logic [2:0] k_code;
   logic word16;
   logic [4:0] res_m1;
   logic [1:0] cs;
   logic sync_ok;
   logic pos_last;
   logic local_multiframe_clock_end;
   logic [8:0] idx;
   logic signed [5:0] s_log;
   logic [4:0] s_val;
   logic hd;
   logic [31:0] status;

   // 8b/10b encode, returns new running disparity and symbol
   function automatic logic [10:0] encode(input logic [7:0] d, input logic k, input logic rd);
      logic [5:0] c6;
      logic [3:0] c4;
      logic rd1;
      logic rd2;
      logic comp4;
      c6 = k ? jesd_tx_pkg::ENC6_K28 : jesd_tx_pkg::ENC6_TABLE[d[4:0]];
      rd1 = ($countones(c6) != 3) ? ~rd : rd;
      if (rd && (($countones(c6) != 3) || (d[4:0] == 5'h07 && !k))) begin
         c6 = ~c6;
      end
      c4 = jesd_tx_pkg::ENC4_TABLE[d[7:5]];
      if (d[7:5] == 3'h7 && (k || (!rd1 && (d[4:0] == 5'h11 || d[4:0] == 5'h12 || d[4:0] == 5'h14))
            || (rd1 && (d[4:0] == 5'h0B || d[4:0] == 5'h0D || d[4:0] == 5'h0E)))) begin
         c4 = jesd_tx_pkg::ENC4_ALT7;
      end
      rd2 = ($countones(c4) != 2) ? ~rd1 : rd1;
      comp4 = (($countones(c4) != 2) || d[7:5] == 3'h3) ? rd1 : (k && rd);
      if (comp4) begin
         c4 = ~c4;
      end
      return {rd2, c6, c4};
   endfunction

   // self-synchronising scrambler 1 + x^14 + x^15, msb first
   function automatic logic [22:0] scramble(input logic [7:0] d, input logic [14:0] st);
      logic [7:0] o;
      logic [14:0] s;
      s = st;
      o = 8'h00;
      for (int b = 7; b >= 0; b--) begin
         o[b] = d[b] ^ s[13] ^ s[14];
         s = {s[13:0], o[b]};
      end
      return {s, o};
   endfunction

   // link configuration octets 0..13 for one lane
   function automatic logic [7:0] config_octet(input logic [3:0] i, input logic [1:0] lane, input state_type q,
         input logic [4:0] s_v, input logic h);
      logic [7:0] t [14];
      logic [7:0] sum;
      t[0] = q.ident[7:0];
      t[1] = {4'h0, q.ident[11:8]};
      t[2] = {6'h00, lane};
      t[3] = {q.ctrl[jesd_tx_pkg::CTRL_SCRAMBLE_BIT], 2'h0, 5'((5'h01 << q.fmt[1:0]) - 5'h01)};
      t[4] = 8'((8'h01 << q.fmt[6:4]) - 8'h01);
      t[5] = {3'h0, q.fmt[16:14], 2'h3};
      t[6] = 8'((8'h01 << q.fmt[3:2]) - 8'h01);
      t[7] = {q.fmt[13:12], 2'h0, q.fmt[11:8]};
      t[8] = {3'h1, q.fmt[7] ? 5'h0F : 5'h07};
      t[9] = {3'h1, 5'(s_v - 5'h01)};
      t[10] = {h, 7'h00};
      t[11] = 8'h00;
      t[12] = 8'h00;
      sum = 8'h00;
      for (int j = 0; j < 13; j++) begin
         sum = 8'(sum + t[j]);
      end
      t[13] = sum;
      return t[i];
   endfunction

   // byte-lane write merge
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] s);
      logic [31:0] m;
      for (int b = 0; b < 4; b++) begin
         m[b*8 +: 8] = s[b] ? d[b*8 +: 8] : old[b*8 +: 8];
      end
      return m;
   endfunction

   // field decode and derived parameters
   always_comb begin
      f_code = r.fmt[jesd_tx_pkg::FMT_OCTETS_LSB +: 3];
      l_code = r.fmt[jesd_tx_pkg::FMT_LANES_LSB +: 2];
      m_code = r.fmt[jesd_tx_pkg::FMT_CONV_LSB +: 2];
      k_code = r.fmt[jesd_tx_pkg::FMT_FRAMES_LSB +: 3];
      word16 = r.fmt[jesd_tx_pkg::FMT_WORD16_BIT];
      res_m1 = {1'b0, r.fmt[jesd_tx_pkg::FMT_RES_LSB +: 4]};
      cs = r.fmt[jesd_tx_pkg::FMT_CS_LSB +: 2];
      sync_ok = r.pin_b[0];
      pos_last = r.pos == 4'((5'h01 << f_code) - 5'h01);
      local_multiframe_clock_end = pos_last && r.frame == {k_code, 2'h3};
      idx = 9'((9'(r.frame) << f_code) | 9'(r.pos));
      s_log = 6'(signed'({3'h0, f_code}) + signed'({4'h0, l_code}) + 6'sd3 - signed'({4'h0, m_code})
         - (word16 ? 6'sd4 : 6'sd3));
      s_val = (s_log < 0) ? 5'h00 : 5'(5'h01 << s_log[2:0]);
      hd = word16 && f_code == 3'h0;
      status = 32'h0000_0000;
      status[2:0] = r.state;
      status[jesd_tx_pkg::STAT_SYNC_BIT] = sync_ok;
      status[jesd_tx_pkg::STAT_HD_BIT] = hd;
      status[jesd_tx_pkg::STAT_S_LSB +: 5] = s_val;
   end

   // next-state logic for bus, link and lanes
   always_comb begin
      logic [15:0] word;
      logic [7:0] raw;
      logic [7:0] oct;
      logic [22:0] sr;
      logic kc;
      logic [10:0] e;
      logic [4:0] tail;
      logic [2:0] cbits;
      word = 16'h0000;
      raw = 8'h00;
      oct = 8'h00;
      sr = 23'h0;
      kc = 1'b0;
      e = 11'h0;
      tail = 5'h00;
      cbits = 3'h0;
      n = r;
      // pin synchronisers: sysref, overrange, fast detect, sync request
      n.pin_a = {sysref, overrange, fast_detect, sync_request_n};
      n.pin_b = r.pin_a;
      n.sysref_d = r.pin_b[3];
      n.prn = {r.prn[14:0], r.prn[15] ^ r.prn[14] ^ r.prn[12] ^ r.prn[3]};
      // write channel: address and data in either order
      if (awvalid && r.awready) begin
         n.aw_held = 1'b1;
         n.aw_addr = awaddr;
      end
      if (wvalid && r.wready) begin
         n.w_held = 1'b1;
         n.w_data = wdata;
         n.w_strb = wstrb;
      end
      if (r.bvalid && bready) begin
         n.bvalid = 1'b0;
      end
      if (r.aw_held && r.w_held && !r.bvalid) begin
         n.aw_held = 1'b0;
         n.w_held = 1'b0;
         n.bvalid = 1'b1;
         n.bresp = jesd_tx_pkg::RESP_OKAY;
         unique case (r.aw_addr)
            jesd_tx_pkg::CTRL_OFFSET: n.ctrl = merge(r.ctrl, r.w_data, r.w_strb) & 32'h0000_001F;
            jesd_tx_pkg::FORMAT_OFFSET: n.fmt = merge(r.fmt, r.w_data, r.w_strb) & 32'h0001_FFFF;
            jesd_tx_pkg::IDENT_OFFSET: n.ident = merge(r.ident, r.w_data, r.w_strb) & 32'h0000_0FFF;
            jesd_tx_pkg::STATUS_OFFSET: n.bresp = jesd_tx_pkg::RESP_OKAY;
            default: n.bresp = jesd_tx_pkg::RESP_SLVERR;
         endcase
      end
      n.awready = !n.aw_held;
      n.wready = !n.w_held;
      // read channel
      if (r.rvalid && rready) begin
         n.rvalid = 1'b0;
      end
      if (arvalid && r.arready) begin
         n.rvalid = 1'b1;
         n.rresp = jesd_tx_pkg::RESP_OKAY;
         unique case (araddr)
            jesd_tx_pkg::CTRL_OFFSET: n.rdata = r.ctrl;
            jesd_tx_pkg::FORMAT_OFFSET: n.rdata = r.fmt;
            jesd_tx_pkg::STATUS_OFFSET: n.rdata = status;
            jesd_tx_pkg::IDENT_OFFSET: n.rdata = r.ident;
            default: begin
               n.rdata = 32'h0000_0000;
               n.rresp = jesd_tx_pkg::RESP_SLVERR;
            end
         endcase
      end
      n.arready = !n.rvalid;
      // local multiframe clock, realigned by sysref rising edge
      if (r.pin_b[3] && !r.sysref_d) begin
         n.pos = 4'h0;
         n.frame = 5'h00;
      end else if (pos_last) begin
         n.pos = 4'h0;
         n.frame = (r.frame == {k_code, 2'h3}) ? 5'h00 : 5'(r.frame + 5'h01);
      end else begin
         n.pos = 4'(r.pos + 4'h1);
      end
      // link establishment sequence
      unique case (r.state)
         jesd_tx_pkg::st_idle: n.state = jesd_tx_pkg::st_cgs;
         jesd_tx_pkg::st_cgs: begin
            if (sync_ok) begin
               n.state = jesd_tx_pkg::st_wait;
            end
         end
         jesd_tx_pkg::st_wait: begin
            if (local_multiframe_clock_end) begin
               n.state = jesd_tx_pkg::st_initial_alignment_sequence;
               n.mf = 2'h0;
            end
         end
         jesd_tx_pkg::st_initial_alignment_sequence: begin
            if (local_multiframe_clock_end) begin
               n.mf = 2'(r.mf + 2'h1);
               if (r.mf == 2'h3) begin
                  n.state = jesd_tx_pkg::st_data;
               end
            end
         end
         jesd_tx_pkg::st_data: n.state = jesd_tx_pkg::st_data;
      endcase
      if (!r.ctrl[jesd_tx_pkg::CTRL_ENABLE_BIT]) begin
         n.state = jesd_tx_pkg::st_idle;
      end else if (!sync_ok && r.state != jesd_tx_pkg::st_idle) begin
         n.state = jesd_tx_pkg::st_cgs;
      end
      // per-lane octet selection and encoding
      for (int l = 0; l < 4; l++) begin
         kc = 1'b1;
         oct = jesd_tx_pkg::CHAR_K;
         unique case (r.state)
            jesd_tx_pkg::st_initial_alignment_sequence: begin
               kc = 1'b0;
               oct = idx[7:0];
               if (idx == 9'h000) begin
                  kc = 1'b1;
                  oct = jesd_tx_pkg::CHAR_R;
               end else if (local_multiframe_clock_end) begin
                  kc = 1'b1;
                  oct = jesd_tx_pkg::CHAR_A;
               end else if (r.mf == 2'h1 && idx == 9'h001) begin
                  kc = 1'b1;
                  oct = jesd_tx_pkg::CHAR_Q;
               end else if (r.mf == 2'h1 && idx >= 9'h002 && idx <= 9'h00F) begin
                  oct = config_octet(4'(idx - 9'h002), 2'(l), r, s_val, hd);
               end
            end
            jesd_tx_pkg::st_data: begin
               kc = 1'b0;
               // sample, control bits, then tail bits
               cbits = 3'(r.pin_b[3:1] >> (2'h3 - cs));
               // sample left-justified, control bits just below it, tails fill the rest
               tail = 5'(5'h0F - res_m1 - 5'(cs));
               word = 16'(lane_samples[l*16 +: 16] << (5'h0F - res_m1)) | 16'(16'(cbits) << tail);
               if (r.ctrl[jesd_tx_pkg::CTRL_TAIL_RANDOM_BIT]) begin
                  word = word | (r.prn & 16'((17'h00001 << tail) - 17'h00001));
               end
               // high octet first, low octet next
               if (word16 && r.pos[0]) begin
                  raw = r.low_byte[l];
               end else begin
                  raw = word[15:8];
                  n.low_byte[l] = word[7:0];
               end
               oct = raw;
               if (r.ctrl[jesd_tx_pkg::CTRL_SCRAMBLE_BIT]) begin
                  sr = scramble(raw, r.scr[l]);
                  n.scr[l] = sr[22:8];
                  oct = sr[7:0];
                  if (r.ctrl[jesd_tx_pkg::CTRL_ALIGN_INSERT_BIT] && local_multiframe_clock_end && oct == jesd_tx_pkg::CHAR_A) begin
                     kc = 1'b1;
                  end else if (r.ctrl[jesd_tx_pkg::CTRL_ALIGN_INSERT_BIT] && pos_last
                        && oct == jesd_tx_pkg::CHAR_F) begin
                     kc = 1'b1;
                  end
               end else if (pos_last) begin
                  n.last_oct[l] = raw;
                  if (r.ctrl[jesd_tx_pkg::CTRL_ALIGN_INSERT_BIT] && raw == r.last_oct[l]) begin
                     kc = 1'b1;
                     oct = local_multiframe_clock_end ? jesd_tx_pkg::CHAR_A : jesd_tx_pkg::CHAR_F;
                  end
               end
            end
            default: kc = 1'b1;
         endcase
         e = encode(oct, kc, r.rd[l]);
         n.rd[l] = e[10];
         n.sym[l] = e[9:0];
      end
      n.lane_en = (l_code == 2'h0) ? 4'h1 : (l_code == 2'h1) ? 4'h3 : 4'hF;
      n.sample_ready = n.state == jesd_tx_pkg::st_data && (!word16 || !n.pos[0]);
   end

   // state register, defaults on reset
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         r <= '0;
         r.ctrl <= jesd_tx_pkg::CTRL_RESET;
         r.fmt <= jesd_tx_pkg::FORMAT_RESET;
         r.ident <= jesd_tx_pkg::IDENT_RESET;
         r.awready <= 1'b1;
         r.wready <= 1'b1;
         r.arready <= 1'b1;
         r.prn <= 16'hACE1;
      end else begin
         r <= n;
      end
   end

   // outputs straight from flops
   assign awready = r.awready;
   assign wready = r.wready;
   assign bvalid = r.bvalid;
   assign bresp = r.bresp;
   assign arready = r.arready;
   assign rvalid = r.rvalid;
   assign rdata = r.rdata;
   assign rresp = r.rresp;
   assign lane_symbols = r.sym;
   assign lane_enable = r.lane_en;
   assign sample_ready = r.sample_ready;

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   sequence s_local_multiframe_clock_edge;
      r.state == jesd_tx_pkg::st_wait && local_multiframe_clock_end && sync_ok && r.ctrl[0];
   endsequence
   sequence s_initial_alignment_sequence_first;
      r.state == jesd_tx_pkg::st_initial_alignment_sequence && idx == 9'h000;
   endsequence

   a_cgs_comma: assert property (r.state == jesd_tx_pkg::st_cgs |=>
      lane_symbols[9:0] == jesd_tx_pkg::SYM_K_NEG || lane_symbols[9:0] == jesd_tx_pkg::SYM_K_POS)
      else $error("comma missing during code group sync");
   a_cgs_hold: assert property (r.state == jesd_tx_pkg::st_cgs && !sync_ok |=>
      r.state == jesd_tx_pkg::st_cgs || r.state == jesd_tx_pkg::st_idle)
      else $error("left code group sync while sync request low");
   a_resync_cgs: assert property (r.state == jesd_tx_pkg::st_data && !sync_ok && r.ctrl[0] |=>
      r.state == jesd_tx_pkg::st_cgs)
      else $error("data continued after sync request");
   a_initial_alignment_sequence_boundary: assert property (s_local_multiframe_clock_edge |=> r.state == jesd_tx_pkg::st_initial_alignment_sequence && r.pos == 4'h0)
      else $error("alignment sequence not started on boundary");
   a_initial_alignment_sequence_start_r: assert property (s_initial_alignment_sequence_first |=>
      lane_symbols[9:0] == jesd_tx_pkg::SYM_R_NEG || lane_symbols[9:0] == jesd_tx_pkg::SYM_R_POS)
      else $error("multiframe does not start with R");
   a_initial_alignment_sequence_q_char: assert property (r.state == jesd_tx_pkg::st_initial_alignment_sequence && r.mf == 2'h1 && idx == 9'h001 |=>
      lane_symbols[9:0] == jesd_tx_pkg::SYM_Q_NEG || lane_symbols[9:0] == jesd_tx_pkg::SYM_Q_POS)
      else $error("Q missing in configuration multiframe");
   a_initial_alignment_sequence_unscrambled: assert property (r.state == jesd_tx_pkg::st_initial_alignment_sequence |=> $stable(r.scr))
      else $error("scrambler advanced during alignment sequence");
   a_ready_data: assert property (sample_ready |-> r.state == jesd_tx_pkg::st_data ##1
      (!word16 || !sample_ready))
      else $error("sample ready outside data or on odd octet");
   a_lane_count: assert property (l_code == 2'h1 |=> lane_enable == 4'h3)
      else $error("lane enables do not match lane count");

endmodule

// ===== verilog/jesd_tx_pkg.sv
package jesd_tx_pkg;
   // register byte offsets
   localparam logic [7:0] CTRL_OFFSET = 8'h00;
   localparam logic [7:0] FORMAT_OFFSET = 8'h04;
   localparam logic [7:0] STATUS_OFFSET = 8'h08;
   localparam logic [7:0] IDENT_OFFSET = 8'h0C;
   // control fields: enable, scramble, tail random, alignment insertion
   localparam int CTRL_ENABLE_BIT = 0;
   localparam int CTRL_SCRAMBLE_BIT = 1;
   localparam int CTRL_TAIL_RANDOM_BIT = 2;
   localparam int CTRL_ALIGN_INSERT_BIT = 4;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0013;
   // format fields: lanes code, converters code, octets code, 16-bit word, resolution-1, cs, frames code
   localparam int FMT_LANES_LSB = 0;
   localparam int FMT_CONV_LSB = 2;
   localparam int FMT_OCTETS_LSB = 4;
   localparam int FMT_WORD16_BIT = 7;
   localparam int FMT_RES_LSB = 8;
   localparam int FMT_CS_LSB = 12;
   localparam int FMT_FRAMES_LSB = 14;
   localparam logic [31:0] FORMAT_RESET = 32'h0001_CD91;
   // device and bank identifiers for link configuration, values arbitrary
   localparam logic [31:0] IDENT_RESET = 32'h0000_015A;
   // status fields
   localparam int STAT_SYNC_BIT = 3;
   localparam int STAT_HD_BIT = 4;
   localparam int STAT_S_LSB = 8;
   // axi responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // control characters as octets, then as 10-bit symbols
   localparam logic [7:0] CHAR_R = 8'h1C;
   localparam logic [7:0] CHAR_A = 8'h7C;
   localparam logic [7:0] CHAR_Q = 8'h9C;
   localparam logic [7:0] CHAR_K = 8'hBC;
   localparam logic [7:0] CHAR_F = 8'hFC;
   localparam logic [9:0] SYM_K_NEG = 10'h0FA;
   localparam logic [9:0] SYM_K_POS = 10'h305;
   localparam logic [9:0] SYM_R_NEG = 10'h0F4;
   localparam logic [9:0] SYM_R_POS = 10'h30B;
   localparam logic [9:0] SYM_Q_NEG = 10'h0F2;
   localparam logic [9:0] SYM_Q_POS = 10'h30D;
   // 5b/6b and 3b/4b codes for negative disparity, abcdei and fghj
   localparam logic [5:0] ENC6_TABLE [32] = '{6'h27, 6'h1D, 6'h2D, 6'h31, 6'h35, 6'h29, 6'h19, 6'h38,
      6'h39, 6'h25, 6'h15, 6'h34, 6'h0D, 6'h2C, 6'h1C, 6'h17, 6'h1B, 6'h23, 6'h13, 6'h32, 6'h0B, 6'h2A,
      6'h1A, 6'h3A, 6'h33, 6'h26, 6'h16, 6'h36, 6'h0E, 6'h2E, 6'h1E, 6'h2B};
   localparam logic [3:0] ENC4_TABLE [8] = '{4'hB, 4'h9, 4'h5, 4'hC, 4'hD, 4'hA, 4'h6, 4'hE};
   localparam logic [5:0] ENC6_K28 = 6'h0F;
   localparam logic [3:0] ENC4_ALT7 = 4'h7;
   typedef enum logic [2:0] {
      st_idle = 3'b000,
      st_cgs = 3'b001,
      st_wait = 3'b010,
      st_initial_alignment_sequence = 3'b011,
      st_data = 3'b100
   } link_state_type;
endpackage
